// file: include/column_dac_cfg.svh
`ifndef COLUMN_DAC_CFG_SVH
`define COLUMN_DAC_CFG_SVH
// Behaviour
// R1 - Transfer starts six-cycle load of twelve latches
// R2 - Two words per clock period, both edges
// R3 - Transfer copies loaded words to outputs
// R4 - Transfer also starts a new loading sequence
// R5 - Direction low ascends 0-11, high descends
// R6 - Polarity captured on edge after transfer
// R7 - Captured polarity reaches outputs next transfer
// R8 - Code 0 full swing, 1023 none
// R9 - Pin select, switch low: outputs grounded
// R10 - Pin select, switch high: outputs normal
// R11 - Serial select: switch pin ignored
// R12 - Thermal guard enable high enables protection
// R13 - Twelve-bit word: mode, load, unused, code
// R14 - Bit 11 selects grounded mode at completion
// R15 - Bit 10 high loads auxiliary DAC code
// R16 - Frame enable falling starts word, no change
// R17 - Pin select: bit 11 ignored, bit 10 kept
// R18 - Auxiliary level follows received 8-bit code
// R19 - Transfer start sampled on rising edges only
// R20 - Frame enable rising edge applies the word
// R21 - Twelve bits shifted MSB first while framed
// R22 - Separate input and output latch ranks

`define CHANNELS 12
`define WORD_W 10
`define CHAN_IDX_W 4
`define CHAN_LAST 4'hb
`define CODE_MAX 10'h3ff
`define PAIRS_LAST 3'h5
`define PAIR_CNT_W 3
`define SER_BITS 4'hc
`define SER_CNT_W 4
`define SER_W 12
`define SER_MODE_BIT 11
`define SER_LOAD_BIT 10
`define AUX_W 8
`define AUX_RESET 8'h00
`define FIFO_DEPTH 32
`endif

// file: include/column_dac_pkg.sv
`include "column_dac_cfg.svh"
package column_dac_pkg;
    typedef logic [`WORD_W-1:0] word_t;
    typedef logic [`CHANNELS-1:0][`WORD_W-1:0] chan_rank_t;

    typedef struct packed {
        word_t rise;
        word_t fall;
    } pixel_pair_t;

    typedef enum logic [1:0] {
        LOAD_IDLE = 2'b00,
        LOAD_RUN = 2'b01,
        LOAD_DONE = 2'b10
    } load_state_t;

    typedef struct packed {
        load_state_t load_st;
        logic [`PAIR_CNT_W-1:0] pair_cnt;
        logic dir;
        logic xfr_seen;
        chan_rank_t in_rank;
        chan_rank_t out_rank;
        chan_rank_t swing;
        logic pol_pending;
        logic pol_out;
        logic scl_prev;
        logic sen_prev;
        logic [`SER_W-1:0] shift;
        logic [`SER_CNT_W-1:0] bit_cnt;
        logic ser_ground;
        logic [`AUX_W-1:0] aux_code;
        logic aux_loaded;
        logic grounded;
        logic thermal;
        logic busy;
        logic word_error;
    } ctrl_state_t;
endpackage

// file: src/pixel_fifo.sv
module pixel_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic not_full;
    } fifo_state_t;

    fifo_state_t s_reg;
    fifo_state_t s_next;
    logic push;
    logic pop;

    assign in_ready = s_reg.not_full;
    assign out_valid = (s_reg.cnt != '0);
    assign out_data = s_reg.mem[s_reg.rp];
    assign push = in_valid && s_reg.not_full;
    assign pop = out_valid && out_ready;

    always_comb begin
        s_next = s_reg;
        if (push) begin
            s_next.mem[s_reg.wp] = in_data;
            s_next.wp = (s_reg.wp == AW'(DEPTH - 1)) ? '0 : s_reg.wp + 1'b1;
        end
        if (pop) begin
            s_next.rp = (s_reg.rp == AW'(DEPTH - 1)) ? '0 : s_reg.rp + 1'b1;
        end
        if (push && !pop) begin
            s_next.cnt = s_reg.cnt + 1'b1;
        end else if (pop && !push) begin
            s_next.cnt = s_reg.cnt - 1'b1;
        end
        s_next.not_full = (s_next.cnt != (AW+1)'(DEPTH));
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_reg <= '{mem: '0, wp: '0, rp: '0, cnt: '0, not_full: 1'b1};
        end else begin
            s_reg <= s_next;
        end
    end
endmodule

// file: src/column_dac_ctrl.sv
`include "column_dac_cfg.svh"
module column_dac_ctrl #(
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic PIXEL_VALID,
    input column_dac_pkg::pixel_pair_t PIXEL_PAIR,
    output logic PIXEL_READY,
    input wire logic TRANSFER_START,
    input wire logic LOAD_DIRECTION,
    input wire logic POLARITY_INVERT,
    input wire logic MODE_SOURCE_SELECT,
    input wire logic OUTPUT_GROUND_SWITCH,
    input wire logic THERMAL_GUARD_ENABLE,
    input wire logic SERIAL_SHIFT_CLOCK,
    input wire logic SERIAL_FRAME_ENABLE,
    input wire logic SERIAL_DATA_IN,
    output column_dac_pkg::chan_rank_t COLUMN_CODE,
    output column_dac_pkg::chan_rank_t COLUMN_SWING,
    output logic COLUMN_POLARITY,
    output logic OUTPUT_GROUNDED,
    output logic [`AUX_W-1:0] AUX_DAC_CODE,
    output logic AUX_DAC_LOADED,
    output logic THERMAL_GUARD_ON,
    output logic LOAD_BUSY,
    output logic SERIAL_WORD_ERROR
);
    localparam int PAIR_W = 2 * `WORD_W;

    column_dac_pkg::ctrl_state_t s_reg;
    column_dac_pkg::ctrl_state_t s_next;

    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [PAIR_W-1:0] fifo_out_data;
    column_dac_pkg::pixel_pair_t pair_in;
    logic fifo_ready;

    // Channel number for one word of a pair
    function automatic logic [`CHAN_IDX_W-1:0] chan_index(
        input logic dir,
        input logic [`PAIR_CNT_W-1:0] pair,
        input logic odd
    );
        logic [`CHAN_IDX_W-1:0] base;
        base = {pair, odd};
        chan_index = dir ? (`CHAN_LAST - base) : base;
    endfunction

    // Input stream buffer between source and latch loader
    pixel_fifo #(
        .WIDTH(PAIR_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(CLK),
        .reset(RESET),
        .in_valid(PIXEL_VALID),
        .in_data(PIXEL_PAIR),
        .in_ready(fifo_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(fifo_out_ready)
    );

    assign pair_in = column_dac_pkg::pixel_pair_t'(fifo_out_data);

    // Pops only while a sequence runs and no transfer is due
    assign fifo_out_ready = (s_reg.load_st == column_dac_pkg::LOAD_RUN)
                            && !s_reg.xfr_seen;

    always_comb begin
        logic scl_rise;
        logic sen_rise;
        logic sen_fall;
        logic pop;
        logic [`CHAN_IDX_W-1:0] ch_a;
        logic [`CHAN_IDX_W-1:0] ch_b;
        scl_rise = 1'b0;
        sen_rise = 1'b0;
        sen_fall = 1'b0;
        pop = 1'b0;
        ch_a = '0;
        ch_b = '0;
        s_next = s_reg;

        // Transfer start is looked at on each rising edge only
        s_next.xfr_seen = TRANSFER_START; // R19

        // Loading sequence
        pop = fifo_out_valid && fifo_out_ready;
        if (s_reg.xfr_seen) begin
            s_next.out_rank = s_reg.in_rank; // R3 R22
            for (int i = 0; i < `CHANNELS; i++) begin
                s_next.swing[i] = `CODE_MAX - s_reg.in_rank[i]; // R8
            end
            s_next.pol_out = s_reg.pol_pending; // R7
            s_next.pol_pending = POLARITY_INVERT; // R6
            s_next.dir = LOAD_DIRECTION; // R5
            s_next.pair_cnt = '0; // R4
            s_next.load_st = column_dac_pkg::LOAD_RUN; // R1 R4
        end else begin
            case (s_reg.load_st)
                column_dac_pkg::LOAD_IDLE: begin
                    s_next.load_st = column_dac_pkg::LOAD_IDLE;
                end
                column_dac_pkg::LOAD_RUN: begin
                    if (pop) begin
                        ch_a = chan_index(s_reg.dir, s_reg.pair_cnt, 1'b0);
                        ch_b = chan_index(s_reg.dir, s_reg.pair_cnt, 1'b1);
                        s_next.in_rank[ch_a] = pair_in.rise; // R2 R5
                        s_next.in_rank[ch_b] = pair_in.fall; // R2 R5
                        if (s_reg.pair_cnt == `PAIRS_LAST) begin
                            s_next.load_st = column_dac_pkg::LOAD_DONE; // R1
                        end else begin
                            s_next.pair_cnt = s_reg.pair_cnt + 1'b1; // R1
                        end
                    end
                end
                column_dac_pkg::LOAD_DONE: begin
                    s_next.load_st = column_dac_pkg::LOAD_DONE;
                end
                default: begin
                    s_next.load_st = column_dac_pkg::LOAD_IDLE;
                end
            endcase
        end
        s_next.busy = (s_next.load_st == column_dac_pkg::LOAD_RUN);

        // Serial port, sampled in the clock domain
        s_next.scl_prev = SERIAL_SHIFT_CLOCK;
        s_next.sen_prev = SERIAL_FRAME_ENABLE;
        scl_rise = SERIAL_SHIFT_CLOCK && !s_reg.scl_prev;
        sen_rise = SERIAL_FRAME_ENABLE && !s_reg.sen_prev;
        sen_fall = !SERIAL_FRAME_ENABLE && s_reg.sen_prev;
        s_next.word_error = 1'b0;
        s_next.aux_loaded = 1'b0;

        if (sen_fall) begin
            s_next.bit_cnt = '0; // R16
        end else if (!SERIAL_FRAME_ENABLE && scl_rise) begin
            if (s_reg.bit_cnt != `SER_BITS) begin
                s_next.shift = {s_reg.shift[`SER_W-2:0], SERIAL_DATA_IN}; // R21
                s_next.bit_cnt = s_reg.bit_cnt + 1'b1; // R21
            end else begin
                s_next.word_error = 1'b1;
            end
        end

        if (sen_rise) begin
            if (s_reg.bit_cnt == `SER_BITS) begin
                if (MODE_SOURCE_SELECT) begin
                    s_next.ser_ground = s_reg.shift[`SER_MODE_BIT]; // R14 R20
                end
                if (s_reg.shift[`SER_LOAD_BIT]) begin
                    s_next.aux_code = s_reg.shift[`AUX_W-1:0]; // R15 R18
                    s_next.aux_loaded = 1'b1; // R20
                end
            end else begin
                s_next.word_error = 1'b1; // R13
            end
        end

        // Output mode source
        if (MODE_SOURCE_SELECT) begin
            s_next.grounded = s_next.ser_ground; // R11
        end else begin
            s_next.grounded = !OUTPUT_GROUND_SWITCH; // R9 R10 R17
        end

        s_next.thermal = THERMAL_GUARD_ENABLE; // R12
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            s_reg <= '{
                load_st: column_dac_pkg::LOAD_IDLE,
                pair_cnt: '0,
                dir: 1'b0,
                xfr_seen: 1'b0,
                in_rank: '0,
                out_rank: '0,
                swing: {`CHANNELS{`CODE_MAX}},
                pol_pending: 1'b0,
                pol_out: 1'b0,
                scl_prev: 1'b0,
                sen_prev: 1'b1,
                shift: '0,
                bit_cnt: '0,
                ser_ground: 1'b0,
                aux_code: `AUX_RESET,
                aux_loaded: 1'b0,
                grounded: 1'b0,
                thermal: 1'b0,
                busy: 1'b0,
                word_error: 1'b0
            };
        end else begin
            s_reg <= s_next;
        end
    end

    assign PIXEL_READY = fifo_ready;
    assign COLUMN_CODE = s_reg.out_rank;
    assign COLUMN_SWING = s_reg.swing;
    assign COLUMN_POLARITY = s_reg.pol_out;
    assign OUTPUT_GROUNDED = s_reg.grounded;
    assign AUX_DAC_CODE = s_reg.aux_code;
    assign AUX_DAC_LOADED = s_reg.aux_loaded;
    assign THERMAL_GUARD_ON = s_reg.thermal;
    assign LOAD_BUSY = s_reg.busy;
    assign SERIAL_WORD_ERROR = s_reg.word_error;
endmodule

// file: tb/column_dac_checker.sv
module column_dac_checker (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic TRANSFER_START,
    input wire logic MODE_SOURCE_SELECT,
    input wire logic OUTPUT_GROUND_SWITCH,
    input wire logic THERMAL_GUARD_ENABLE,
    input wire logic SERIAL_FRAME_ENABLE,
    input column_dac_pkg::chan_rank_t COLUMN_CODE,
    input column_dac_pkg::chan_rank_t COLUMN_SWING,
    input wire logic COLUMN_POLARITY,
    input wire logic OUTPUT_GROUNDED,
    input wire logic [7:0] AUX_DAC_CODE,
    input wire logic AUX_DAC_LOADED,
    input wire logic THERMAL_GUARD_ON,
    input wire logic LOAD_BUSY
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    property p_swing; COLUMN_SWING == ~COLUMN_CODE; endproperty
    a_swing: assert property (p_swing) else $error("swing");
    property p_code;
        $changed(COLUMN_CODE) |-> $past(TRANSFER_START, 2);
    endproperty
    a_code: assert property (p_code) else $error("code moved");
    property p_busy; TRANSFER_START |-> ##2 LOAD_BUSY; endproperty
    a_busy: assert property (p_busy) else $error("no load");
    property p_pol;
        $changed(COLUMN_POLARITY) |-> $past(TRANSFER_START, 2);
    endproperty
    a_pol: assert property (p_pol) else $error("polarity");
    property p_gnd;
        !MODE_SOURCE_SELECT && !OUTPUT_GROUND_SWITCH |=> OUTPUT_GROUNDED;
    endproperty
    a_gnd: assert property (p_gnd) else $error("not grounded");
    property p_norm;
        !MODE_SOURCE_SELECT && OUTPUT_GROUND_SWITCH |=> !OUTPUT_GROUNDED;
    endproperty
    a_norm: assert property (p_norm) else $error("not normal");
    property p_therm;
        1'b1 |=> THERMAL_GUARD_ON == $past(THERMAL_GUARD_ENABLE);
    endproperty
    a_therm: assert property (p_therm) else $error("thermal");
    property p_aux; $changed(AUX_DAC_CODE) |-> AUX_DAC_LOADED; endproperty
    a_aux: assert property (p_aux) else $error("aux moved");
    property p_apply;
        AUX_DAC_LOADED |-> SERIAL_FRAME_ENABLE ##1 !AUX_DAC_LOADED;
    endproperty
    a_apply: assert property (p_apply) else $error("apply");
    property p_start;
        $fell(SERIAL_FRAME_ENABLE) |-> ##1 $stable(AUX_DAC_CODE) [*2];
    endproperty
    a_start: assert property (p_start) else $error("frame start");
    c_load: cover property (AUX_DAC_LOADED);
    c_done: cover property ($fell(LOAD_BUSY));
    c_pol: cover property (COLUMN_POLARITY);
endmodule

bind column_dac_ctrl column_dac_checker u_column_dac_checker (
    .CLK, .RESET, .TRANSFER_START, .MODE_SOURCE_SELECT,
    .OUTPUT_GROUND_SWITCH, .THERMAL_GUARD_ENABLE, .SERIAL_FRAME_ENABLE,
    .COLUMN_CODE, .COLUMN_SWING, .COLUMN_POLARITY, .OUTPUT_GROUNDED,
    .AUX_DAC_CODE, .AUX_DAC_LOADED, .THERMAL_GUARD_ON, .LOAD_BUSY
);

// file: tb/pixel_source.sv
module pixel_source (
    input wire logic CLK,
    input wire logic PIXEL_READY,
    output logic PIXEL_VALID = 1'b0,
    output column_dac_pkg::pixel_pair_t PIXEL_PAIR = '0,
    output logic SERIAL_SHIFT_CLOCK = 1'b0,
    output logic SERIAL_FRAME_ENABLE = 1'b1,
    output logic SERIAL_DATA_IN = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;
    logic hung = 1'b0;
    task automatic step();
        repeat (2) @(posedge CLK);
        #10;
    endtask
    // Rise word then fall word of one clock period
    task automatic push(input column_dac_pkg::pixel_pair_t p);
        int n;
        PIXEL_VALID = 1'b1;
        PIXEL_PAIR = p;
        for (n = 0; n < 500 && PIXEL_READY !== 1'b1; n++) @(negedge CLK);
        hung = (n == 500);
        @(posedge CLK);
        #10;
    endtask
    task automatic idle();
        PIXEL_VALID = 1'b0;
        PIXEL_PAIR = ~PIXEL_PAIR;
    endtask
    task automatic send(input logic [11:0] w, input int n);
        SERIAL_FRAME_ENABLE = 1'b0;
        step();
        for (int i = 11; i > 11 - n; i--) begin
            SERIAL_DATA_IN = w[i];
            step();
            SERIAL_SHIFT_CLOCK = 1'b1;
            step();
            SERIAL_SHIFT_CLOCK = 1'b0;
        end
        step();
        SERIAL_DATA_IN = ~SERIAL_DATA_IN;
        SERIAL_FRAME_ENABLE = 1'b1;
        step();
        step();
    endtask
endmodule

// file: tb/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic CLK = 1'b0;
    logic RESET = 1'b1;
    logic TRANSFER_START = 1'b0;
    logic LOAD_DIRECTION = 1'b0;
    logic POLARITY_INVERT = 1'b0;
    logic MODE_SOURCE_SELECT = 1'b0;
    logic OUTPUT_GROUND_SWITCH = 1'b1;
    logic THERMAL_GUARD_ENABLE = 1'b0;
    logic PIXEL_VALID, PIXEL_READY, SERIAL_SHIFT_CLOCK;
    logic SERIAL_FRAME_ENABLE, SERIAL_DATA_IN, COLUMN_POLARITY;
    logic OUTPUT_GROUNDED, AUX_DAC_LOADED, THERMAL_GUARD_ON, LOAD_BUSY;
    logic SERIAL_WORD_ERROR;
    int err_pulses = 0;
    logic [7:0] AUX_DAC_CODE;
    column_dac_pkg::pixel_pair_t PIXEL_PAIR;
    column_dac_pkg::chan_rank_t COLUMN_CODE, exp;
    logic [11:0] sw [6] = '{12'hc5a, 12'h8a5, 12'h7c3, 12'h800, 12'h4ff,
        12'h4aa};
    logic [7:0] ea [6] = '{8'h5a, 8'h5a, 8'hc3, 8'hc3, 8'hff, 8'hff};
    logic [5:0] ms = 6'b001100;
    logic [5:0] gs = 6'b100011;
    logic [5:0] eg = 6'b011000;
    int miscompares = 0;
    int cmp_count = 0;
    column_dac_ctrl u_column_dac_ctrl (.CLK, .RESET, .PIXEL_VALID,
        .PIXEL_PAIR, .PIXEL_READY, .TRANSFER_START, .LOAD_DIRECTION,
        .POLARITY_INVERT, .MODE_SOURCE_SELECT, .OUTPUT_GROUND_SWITCH,
        .THERMAL_GUARD_ENABLE, .SERIAL_SHIFT_CLOCK, .SERIAL_FRAME_ENABLE,
        .SERIAL_DATA_IN, .COLUMN_CODE, .COLUMN_SWING(), .COLUMN_POLARITY,
        .OUTPUT_GROUNDED, .AUX_DAC_CODE, .AUX_DAC_LOADED, .THERMAL_GUARD_ON,
        .LOAD_BUSY, .SERIAL_WORD_ERROR);
    pixel_source u_pixel_source (.CLK, .PIXEL_READY, .PIXEL_VALID,
        .PIXEL_PAIR, .SERIAL_SHIFT_CLOCK, .SERIAL_FRAME_ENABLE,
        .SERIAL_DATA_IN);
    initial forever #50 CLK = ~CLK;
    // Counts serial word error pulses
    always @(posedge CLK) begin
        if (SERIAL_WORD_ERROR === 1'b1)
            err_pulses++;
    end
    function automatic column_dac_pkg::word_t w(input int k, input int h);
        return 10'(k * 2 + h) ^ 10'h2a5;
    endfunction
    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk_rank(input column_dac_pkg::chan_rank_t g, e);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %0t column codes", $time);
        end
    endtask
    task automatic chk_val(input logic [7:0] g, e, input string m);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %0t %s %h", $time, m, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
        #10;
    endtask
    task automatic put(input int k);
        u_pixel_source.push({w(k, 0), w(k, 1)});
        if (u_pixel_source.hung) begin
            miscompares++;
            summarize();
        end
    endtask
    task automatic xfer(input logic d, p);
        TRANSFER_START = 1'b1;
        LOAD_DIRECTION = d;
        POLARITY_INVERT = p;
        tick(1);
        TRANSFER_START = 1'b0;
        tick(1);
    endtask
    task automatic wait_idle();
        int n;
        for (n = 0; n < 50 && LOAD_BUSY !== 1'b0; n++) tick(1);
        if (n == 50) begin
            miscompares++;
            summarize();
        end
    endtask
    initial begin
        tick(16);
        RESET = 1'b0;
        tick(1);
        for (int k = 0; k < 32; k++) put(k);
        u_pixel_source.idle();
        chk_val(8'(PIXEL_READY), 8'h00, "full");
        for (int t = 0; t < 7; t++) begin
            xfer(t[0], t[1]);
            if (t > 0) begin
                for (int c = 0; c < 12; c++)
                    exp[t[0] ? c : 11 - c] = w(6 * t - 6 + c / 2, c % 2);
                chk_rank(COLUMN_CODE, exp);
                chk_val(8'(COLUMN_POLARITY), 8'((t - 1) / 2 % 2), "pol");
            end
            if (t == 5) begin
                for (int k = 32; k < 36; k++) put(k);
                u_pixel_source.idle();
            end
            if (t < 6)
                wait_idle();
        end
        chk_val(8'(PIXEL_READY), 8'h01, "drained");
        THERMAL_GUARD_ENABLE = 1'b1;
        for (int i = 0; i < 6; i++) begin
            MODE_SOURCE_SELECT = ms[i];
            OUTPUT_GROUND_SWITCH = gs[i];
            u_pixel_source.send(sw[i], i == 5 ? 11 : 12);
            chk_val(AUX_DAC_CODE, ea[i], "aux");
            chk_val(8'(OUTPUT_GROUNDED), 8'(eg[i]), "gnd");
        end
        chk_val(8'(THERMAL_GUARD_ON), 8'h01, "thermal");
        chk_val(8'(err_pulses), 8'h01, "word error");
        summarize();
    end
endmodule
